// ---- shared/tsc_pkg.sv ----
/*
 Shared constants and carriers of the timer synchronisation control block:
 register indices, page codes, command bit positions, reset values and the
 packed structs that carry run bits and reload strobes to the timer cores.
 Assumes a 32-bit Avalon-MM register bus with byte addressing.
*/
package tsc_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] TSC_IDX_CMD   = 8'h95;
    localparam logic [7:0] TSC_IDX_PAGE  = 8'h10;
    localparam logic [7:0] TSC_IDX_RUN   = 8'h11;

    // Page codes selecting the command register behind the shared index
    localparam logic [7:0] TSC_PAGE_START  = 8'h01;
    localparam logic [7:0] TSC_PAGE_RELOAD = 8'h02;
    localparam logic [7:0] TSC_PAGE_STOP   = 8'h03;

    // Command bit positions, common to all three command registers
    localparam int TSC_BIT_T0   = 0;
    localparam int TSC_BIT_T1   = 1;
    localparam int TSC_BIT_T2   = 2;
    localparam int TSC_BIT_T2L  = 5;

    // Run register bit positions
    localparam int TSC_RUN_T0   = 0;
    localparam int TSC_RUN_T1   = 1;
    localparam int TSC_RUN_T2   = 2;
    localparam int TSC_RUN_T2L  = 3;

    // Reset values
    localparam logic [7:0] TSC_RST_CMD  = 8'h00;
    localparam logic [7:0] TSC_RST_PAGE = 8'h00;
    localparam logic [3:0] TSC_RST_RUN  = 4'h0;

    // Run bits handed to the timer cores
    typedef struct packed {
        logic timer2_low_half_run_bit;
        logic timer2_run_bit;
        logic timer1_run_bit;
        logic timer0_run_bit;
    } tsc_run_s;

    // One-cycle forced reload strobes
    typedef struct packed {
        logic timer2_low_count_byte;
        logic timer2_high_count_byte;
        logic timer1_count_bytes;
        logic timer0_count_bytes;
    } tsc_reload_s;

    // Timer 2 configuration seen from its core
    typedef struct packed {
        logic split_mode;
        logic duty_capture_mode;
    } tsc_t2cfg_s;

endpackage

// ---- sim/tsc_timer_sync_bench.sv ----
/*
 Self-checking testbench for the timer synchronisation control block.
 Assumes the block answers each bus request after one wait cycle and that
 the Timer 2 configuration inputs are driven here in place of the core.
*/
`timescale 1ns/1ps
module tsc_timer_sync_bench;
    import tsc_pkg::*;

    logic          clk_i;
    logic          rst_i;
    logic [9:0]    address_i;
    logic          read_i;
    logic          write_i;
    logic [31:0]   writedata_i;
    logic [3:0]    byteenable_i;
    logic [31:0]   readdata_o;
    logic          waitrequest_o;
    tsc_t2cfg_s    t2_cfg_i;
    tsc_run_s      run_o;
    tsc_reload_s   reload_o;
    logic          timer2_low_count_en_o;
    logic [31:0]   rd;
    int            fails;
    int            total_checks;

    tsc_timer_sync dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .address_i             (address_i),
        .read_i                (read_i),
        .write_i               (write_i),
        .writedata_i           (writedata_i),
        .byteenable_i          (byteenable_i),
        .readdata_o            (readdata_o),
        .waitrequest_o         (waitrequest_o),
        .t2_cfg_i              (t2_cfg_i),
        .run_o                 (run_o),
        .reload_o              (reload_o),
        .timer2_low_count_en_o (timer2_low_count_en_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One Avalon transfer; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] data);
        int n;
        @(posedge clk_i);
        read_i       <= ~wr;
        write_i      <= wr;
        address_i    <= {idx, 2'b00};
        writedata_i  <= {24'h00_0000, data};
        byteenable_i <= 4'h1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitrequest_o !== 1'b0 && n < 20);
        if (waitrequest_o !== 1'b0) begin
            fails++;
            wrap_up();
        end
        rd = readdata_o;
        read_i  <= 1'b0;
        write_i <= 1'b0;
    endtask

    // Select a command page, write one command, look at the cycle after
    task automatic cmd(input logic [7:0] page, input logic [7:0] data, input logic [1:0] cfg);
        @(posedge clk_i);
        t2_cfg_i <= cfg;
        bus(1'b1, TSC_IDX_PAGE, page);
        bus(1'b1, TSC_IDX_CMD, data);
        @(negedge clk_i);
    endtask

    task automatic s_start;
        cmd(TSC_PAGE_START, 8'h00, 2'b00);
        chk(run_o, 4'h0);
        cmd(TSC_PAGE_START, 8'h07, 2'b00);
        chk(run_o, 4'h7);
        cmd(TSC_PAGE_START, 8'h20, 2'b00);
        chk(run_o, 4'h7);
        cmd(TSC_PAGE_START, 8'h04, 2'b01);
        chk(run_o, 4'h7);
        cmd(TSC_PAGE_START, 8'h20, 2'b10);
        chk(run_o, 4'hF);
        chk(timer2_low_count_en_o, 1'b1);
        bus(1'b0, TSC_IDX_CMD, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask

    task automatic s_stop;
        logic [7:0] d [3] = '{8'h01, 8'h02, 8'h04};
        logic [3:0] e [3] = '{4'hE, 4'hC, 4'h8};
        cmd(TSC_PAGE_STOP, 8'h00, 2'b10);
        chk(run_o, 4'hF);
        for (int i = 0; i < 3; i++) begin
            cmd(TSC_PAGE_STOP, d[i], 2'b10);
            chk(run_o, e[i]);
        end
        cmd(TSC_PAGE_STOP, 8'h20, 2'b00);
        chk(run_o, 4'h8);
        chk(timer2_low_count_en_o, 1'b0);
        cmd(TSC_PAGE_STOP, 8'h20, 2'b10);
        chk(run_o, 4'h0);
        chk(timer2_low_count_en_o, 1'b0);
    endtask

    task automatic s_reload;
        logic [7:0] d [9] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h04, 8'h04, 8'h20, 8'h20, 8'h00};
        logic [1:0] c [9] = '{2'b00, 2'b00, 2'b00, 2'b10, 2'b01, 2'b11, 2'b10, 2'b00, 2'b00};
        logic [3:0] e [9] = '{4'h1, 4'h2, 4'hC, 4'h4, 4'h0, 4'h0, 4'h8, 4'h0, 4'h0};
        for (int i = 0; i < 9; i++) begin
            cmd(TSC_PAGE_RELOAD, d[i], c[i]);
            chk(reload_o, e[i]);
            @(negedge clk_i);
            chk(reload_o, 4'h0);
        end
        bus(1'b0, TSC_IDX_CMD, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask

    // No page selected and an unmapped index leave everything untouched
    task automatic s_bus;
        cmd(8'h00, 8'h07, 2'b00);
        chk(run_o, 4'h0);
        bus(1'b1, 8'h7F, 8'hFF);
        bus(1'b0, 8'h7F, 8'h00);
        chk(rd, 32'h0000_0000);
        cmd(TSC_PAGE_STOP, 8'h00, 2'b00);
        bus(1'b0, TSC_IDX_CMD, 8'h00);
        chk(rd, 32'h0000_0000);
        cmd(TSC_PAGE_START, 8'h00, 2'b10);
        bus(1'b1, TSC_IDX_RUN, 8'h08);
        @(negedge clk_i);
        chk(timer2_low_count_en_o, 1'b1);
        bus(1'b0, TSC_IDX_RUN, 8'h00);
        chk(rd, 32'h0000_0008);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        @(negedge clk_i);
        chk(run_o, 4'h0);
        chk(timer2_low_count_en_o, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, TSC_IDX_CMD, 8'h00);
        chk(rd, 32'h0000_0000);
    endtask

    initial begin
        fails        = 0;
        total_checks = 0;
        rst_i        = 1'b1;
        read_i       = 1'b0;
        write_i      = 1'b0;
        address_i    = 10'h000;
        writedata_i  = 32'h0000_0000;
        byteenable_i = 4'h0;
        t2_cfg_i     = 2'b00;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        s_start();
        s_stop();
        s_reload();
        s_bus();
        wrap_up();
    end
endmodule

// ---- verilog/tsc_timer_sync.sv ----
/*
 Global start, reload and stop control for Timer 0, Timer 1, Timer 2 (no reload in duty capture mode) and the
 Timer 2 low half in split mode. Software writes one-shot command bits over
 an Avalon-MM slave; the block owns the run bits and drives reload strobes.
 Assumes the timer cores share clk_i, take the run bits as levels, take the
 reload strobes as one-cycle pulses and report the Timer 2 configuration.
*/
`timescale 1ns/1ps

module tsc_timer_sync (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic [9:0]            address_i,
    input  wire logic                  read_i,
    input  wire logic                  write_i,
    input  wire logic [31:0]           writedata_i,
    input  wire logic [3:0]            byteenable_i,
    output logic      [31:0]           readdata_o,
    output logic                       waitrequest_o,
    input  wire tsc_pkg::tsc_t2cfg_s   t2_cfg_i,
    output tsc_pkg::tsc_run_s          run_o,
    output tsc_pkg::tsc_reload_s       reload_o,
    output logic                       timer2_low_count_en_o
);
    import tsc_pkg::*;

    logic        resp_q;
    logic [7:0]  page;
    logic [3:0]  run;
    logic [3:0]  next_run;
    logic [3:0]  reload_q;
    logic [3:0]  next_reload;
    logic [31:0] rdata_q;
    logic [31:0] next_rdata;

    // Bus decode
    wire       req        = read_i | write_i;
    wire       accept     = req & resp_q;
    wire [7:0] idx        = address_i[9:2];
    wire       lane0      = byteenable_i[0];
    wire [7:0] wbyte      = writedata_i[7:0];
    wire       wr_go      = write_i & accept & lane0;
    wire       hit_cmd    = idx == TSC_IDX_CMD;
    wire       hit_page   = idx == TSC_IDX_PAGE;
    wire       hit_run    = idx == TSC_IDX_RUN;
    wire       wr_cmd     = wr_go & hit_cmd;
    wire       wr_start   = wr_cmd & (page == TSC_PAGE_START);
    wire       wr_reload  = wr_cmd & (page == TSC_PAGE_RELOAD);
    wire       wr_stop    = wr_cmd & (page == TSC_PAGE_STOP);
    wire       wr_page    = wr_go & hit_page;
    wire       wr_run     = wr_go & hit_run;
    wire       split      = t2_cfg_i.split_mode;
    wire       duty       = t2_cfg_i.duty_capture_mode;

    // Command bits decoded from the write byte; zeros carry no action
    wire [3:0] start_cmd  = wr_start ? {wbyte[TSC_BIT_T2L] & split, wbyte[TSC_BIT_T2],
                                        wbyte[TSC_BIT_T1], wbyte[TSC_BIT_T0]} : 4'h0;
    wire [3:0] stop_cmd   = wr_stop  ? {wbyte[TSC_BIT_T2L] & split, wbyte[TSC_BIT_T2],
                                        wbyte[TSC_BIT_T1], wbyte[TSC_BIT_T0]} : 4'h0;
    wire       rl_t0      = wr_reload & wbyte[TSC_BIT_T0];
    wire       rl_t1      = wr_reload & wbyte[TSC_BIT_T1];
    wire       rl_t2      = wr_reload & wbyte[TSC_BIT_T2] & ~duty;
    wire       rl_t2l     = wr_reload & wbyte[TSC_BIT_T2L] & split;

    // One wait cycle, then the answer
    assign waitrequest_o = req & ~resp_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            resp_q <= 1'b0;
        end else begin
            resp_q <= req & ~resp_q;
        end
    end

    // Run bits: register write loads them, commands set or clear them
    always_comb begin
        next_run = run;
        if (wr_run) begin
            next_run = wbyte[3:0];
        end
        next_run = (next_run | start_cmd) & ~stop_cmd;
    end

    // Reload strobes; split mode keeps the low byte out of timer2 reload
    always_comb begin
        next_reload = 4'h0;
        next_reload[0] = rl_t0;
        next_reload[1] = rl_t1;
        next_reload[2] = rl_t2;
        next_reload[3] = (rl_t2 & ~split) | rl_t2l;
    end

    // Read mux; command registers hold nothing and read as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_page) begin
            next_rdata = {24'h00_0000, page};
        end else if (hit_run) begin
            next_rdata = {28'h000_0000, run};
        end else if (hit_cmd) begin
            next_rdata = {24'h00_0000, TSC_RST_CMD};
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            page     <= TSC_RST_PAGE;
            run      <= TSC_RST_RUN;
            reload_q <= 4'h0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            if (wr_page) begin
                page <= wbyte;
            end
            run      <= next_run;
            reload_q <= next_reload;
            if (read_i & ~resp_q) begin
                rdata_q <= next_rdata;
            end
        end
    end

    assign readdata_o = rdata_q;

    assign run_o.timer0_run_bit          = run[TSC_RUN_T0];
    assign run_o.timer1_run_bit          = run[TSC_RUN_T1];
    assign run_o.timer2_run_bit          = run[TSC_RUN_T2];
    assign run_o.timer2_low_half_run_bit = run[TSC_RUN_T2L];

    assign reload_o.timer0_count_bytes     = reload_q[0];
    assign reload_o.timer1_count_bytes     = reload_q[1];
    assign reload_o.timer2_high_count_byte = reload_q[2];
    assign reload_o.timer2_low_count_byte  = reload_q[3];

    // Low byte counts only in split mode with its run bit set
    assign timer2_low_count_en_o = split & run[TSC_RUN_T2L];

    // Checks
    a_start_sets_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T0] |=> run_o.timer0_run_bit)
        else $error("timer0 start did not set run bit");

    a_start_sets_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T1] |=> run_o.timer1_run_bit)
        else $error("timer1 start did not set run bit");

    a_start_sets_t2: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T2] |=> run_o.timer2_run_bit)
        else $error("timer2 start did not set run bit");

    a_low_start_split: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T2L] && split |=> run_o.timer2_low_half_run_bit)
        else $error("low half start did not set run bit");

    a_reload_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        reload_q != 4'h0 && !wr_reload |=> reload_q == 4'h0)
        else $error("reload strobe lasted beyond one cycle");

    a_start_together: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[2:0] == 3'b111 |=> run[2:0] == 3'b111)
        else $error("selected timers did not start together");

    a_zero_no_effect: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmd && wbyte == 8'h00 |=> $stable(run) && reload_q == 4'h0)
        else $error("zero command changed timer state");

    a_reload_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T0] |=> reload_o.timer0_count_bytes)
        else $error("timer0 reload strobe missing");

    a_reload_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T1] |=> reload_o.timer1_count_bytes)
        else $error("timer1 reload strobe missing");

    a_reload_t2_full: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T2] && !split && !duty
        |=> reload_o.timer2_high_count_byte && reload_o.timer2_low_count_byte)
        else $error("timer2 full reload missing");

    a_reload_t2_high: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte == 8'h04 && split && !duty
        |=> reload_o.timer2_high_count_byte && !reload_o.timer2_low_count_byte)
        else $error("split timer2 reload touched low byte");

    a_reload_duty_skip: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && duty |=> !reload_o.timer2_high_count_byte)
        else $error("timer2 reload taken in duty capture");

    a_reload_low: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T2L] && split |=> reload_o.timer2_low_count_byte)
        else $error("low half reload strobe missing");

    a_stop_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop |=> (run[2:0] & $past(wbyte[2:0])) == 3'b000)
        else $error("stop command left a run bit set");

    a_low_stop_split: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T2L] && split |=> !run_o.timer2_low_half_run_bit)
        else $error("low half stop did not clear run bit");

    a_low_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T2L] && split ##1 split |-> timer2_low_count_en_o)
        else $error("low byte not counting after low start");

    a_cmd_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        read_i && !resp_q && hit_cmd |=> readdata_o == 32'h0000_0000)
        else $error("command register read nonzero");

    a_low_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmd && !split && !wr_run |=> $stable(run_o.timer2_low_half_run_bit))
        else $error("low half command acted outside split mode");

    a_bus_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(req) |-> waitrequest_o ##1 !waitrequest_o)
        else $error("bus answer not after one wait cycle");

    a_start_keeps_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && !wbyte[TSC_BIT_T0] |=> run_o.timer0_run_bit == $past(run[TSC_RUN_T0]))
        else $error("timer0 run bit changed without start");

    a_start_keeps_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && !wbyte[TSC_BIT_T1] |=> run_o.timer1_run_bit == $past(run[TSC_RUN_T1]))
        else $error("timer1 run bit changed without start");

    a_start_keeps_t2: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && !wbyte[TSC_BIT_T2] |=> run_o.timer2_run_bit == $past(run[TSC_RUN_T2]))
        else $error("timer2 run bit changed without start");

    a_stop_keeps_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && !wbyte[TSC_BIT_T0] |=> run_o.timer0_run_bit == $past(run[TSC_RUN_T0]))
        else $error("timer0 run bit changed without stop");

    a_stop_keeps_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && !wbyte[TSC_BIT_T1] |=> run_o.timer1_run_bit == $past(run[TSC_RUN_T1]))
        else $error("timer1 run bit changed without stop");

    a_stop_keeps_t2: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && !wbyte[TSC_BIT_T2] |=> run_o.timer2_run_bit == $past(run[TSC_RUN_T2]))
        else $error("timer2 run bit changed without stop");

    a_stop_clears_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T0] |=> !run_o.timer0_run_bit)
        else $error("timer0 stop did not clear run bit");

    a_stop_clears_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T1] |=> !run_o.timer1_run_bit)
        else $error("timer1 stop did not clear run bit");

    a_stop_clears_t2: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T2] |=> !run_o.timer2_run_bit)
        else $error("timer2 stop did not clear run bit");

    a_low_start_nosplit: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T2L] && !split
        |=> run_o.timer2_low_half_run_bit == $past(run[TSC_RUN_T2L]))
        else $error("low half start acted outside split mode");

    a_low_stop_nosplit: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T2L] && !split
        |=> run_o.timer2_low_half_run_bit == $past(run[TSC_RUN_T2L]))
        else $error("low half stop acted outside split mode");

    a_low_reload_nosplit: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T2L] && !wbyte[TSC_BIT_T2] && !split
        |=> !reload_o.timer2_low_count_byte)
        else $error("low half reload acted outside split mode");

    a_reload_skip_t0: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && !wbyte[TSC_BIT_T0] |=> !reload_o.timer0_count_bytes)
        else $error("timer0 reload without command bit");

    a_reload_skip_t1: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && !wbyte[TSC_BIT_T1] |=> !reload_o.timer1_count_bytes)
        else $error("timer1 reload without command bit");

    a_reload_skip_t2: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && !wbyte[TSC_BIT_T2] |=> !reload_o.timer2_high_count_byte)
        else $error("timer2 high reload without command bit");

    a_reload_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_reload |=> reload_q == 4'h0)
        else $error("reload strobe without reload write");

    a_split_low_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T2] && !wbyte[TSC_BIT_T2L] && split
        |=> !reload_o.timer2_low_count_byte)
        else $error("split timer2 reload pulsed low byte");

    a_duty_low_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[TSC_BIT_T2] && !wbyte[TSC_BIT_T2L] && duty
        |=> !reload_o.timer2_low_count_byte)
        else $error("timer2 reload reached low byte in duty capture");

    a_start_with_low: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start && wbyte[TSC_BIT_T2L] && wbyte[TSC_BIT_T2] && split
        |=> run[TSC_RUN_T2L] && run[TSC_RUN_T2])
        else $error("timer2 halves did not start together");

    a_stop_together: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[2:0] == 3'b111 |=> run[2:0] == 3'b000)
        else $error("selected timers did not stop together");

    a_reload_together: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload && wbyte[1:0] == 2'b11
        |=> reload_o.timer0_count_bytes && reload_o.timer1_count_bytes)
        else $error("selected reloads did not pulse together");

    a_run_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !wr_start && !wr_stop && !wr_run |=> $stable(run))
        else $error("run bits changed without a command");

    a_low_stop_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_stop && wbyte[TSC_BIT_T2L] && split |=> !timer2_low_count_en_o)
        else $error("low byte still counting after low stop");

    a_reload_keeps_run: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_reload |=> $stable(run))
        else $error("reload command changed run bits");

    a_cmd_no_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_start || wr_stop |=> reload_q == 4'h0)
        else $error("start or stop produced a reload strobe");

    a_other_page: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_cmd && !wr_start && !wr_reload && !wr_stop |=> $stable(run) && reload_q == 4'h0)
        else $error("command on unused page had an effect");

    a_lane_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        write_i && !lane0 |=> $stable(run) && $stable(page))
        else $error("write without low byte lane took effect");

    a_unmapped_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        write_i && !hit_cmd && !hit_page && !hit_run |=> $stable(run) && $stable(page))
        else $error("unmapped write took effect");

    a_wait_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !req |-> !waitrequest_o)
        else $error("wait raised with no request");

    a_answer_once: assert property (@(posedge clk_i) disable iff (rst_i)
        req && !waitrequest_o |=> !resp_q)
        else $error("answer lasted beyond one cycle");

    a_read_page: assert property (@(posedge clk_i) disable iff (rst_i)
        read_i && !resp_q && hit_page |=> readdata_o == {24'h00_0000, $past(page)})
        else $error("page register read wrong");

    a_read_run: assert property (@(posedge clk_i) disable iff (rst_i)
        read_i && !resp_q && hit_run |=> readdata_o == {28'h000_0000, $past(run)})
        else $error("run register read wrong");

    a_read_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
        read_i && !resp_q && !hit_cmd && !hit_page && !hit_run
        |=> readdata_o == 32'h0000_0000)
        else $error("unmapped read nonzero");

    a_read_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !read_i |=> $stable(readdata_o))
        else $error("read data changed without a read");

    a_page_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_page |=> page == $past(wbyte))
        else $error("page write did not land");

    a_run_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_run |=> run == $past(wbyte[3:0]))
        else $error("run register write did not land");

endmodule
